// ==== core/rbs_pkg.sv ====
package rbs_pkg;
  localparam logic [11:0] RBS_BREAK_STANDBY_OFS = 12'h000;
  localparam logic [11:0] RBS_RESET_SOURCE_OFS = 12'h004;
  localparam logic [11:0] RBS_BREAK_FLAG_CTRL_OFS = 12'h00C;
  localparam logic [11:0] RBS_CLOCK_CTRL_OFS = 12'h010;
  localparam logic [11:0] RBS_CAUSE_OFS = 12'h014;
  localparam logic [11:0] RBS_PERIPH_FLAG_OFS = 12'h018;
  // bit positions
  localparam int RBS_STANDBY_EXIT_BIT = 1;
  localparam int RBS_POR_BIT = 7;
  localparam int RBS_PIN_BIT = 6;
  localparam int RBS_WDOG_BIT = 5;
  localparam int RBS_BADOP_BIT = 4;
  localparam int RBS_BADADR_BIT = 3;
  localparam int RBS_LOW_SUPPLY_BIT = 1;
  localparam int RBS_CLEAR_EN_BIT = 7;
  localparam int RBS_BCS_BIT = 0;
  localparam int RBS_OSCEN_BIT = 1;
  // reset values
  localparam logic [7:0] RBS_RESET_SOURCE_POR = 8'h80;
  localparam logic [7:0] RBS_ZERO8 = 8'h00;
  // oscillator on, crystal selected
  localparam logic [1:0] RBS_CLOCK_CTRL_RST = 2'h2;
  localparam logic [1:0] RBS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RBS_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    RBS_CAUSE_NONE,
    RBS_CAUSE_PIN,
    RBS_CAUSE_WDOG,
    RBS_CAUSE_BADOP,
    RBS_CAUSE_BADADR,
    RBS_CAUSE_LOW_SUPPLY
  } rbs_cause_t;
endpackage

// ==== core/rbs_sync.sv ====
`timescale 1ns/1ps
module rbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ==== core/rbs_clkdiv.sv ====
`timescale 1ns/1ps
// base clock enable: a divide-by-two of the chosen source enable
module rbs_clkdiv (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_en,
  input wire logic pll_sel,
  input wire logic crystal_tick,
  input wire logic vco_tick,
  output logic crystal_clock,
  output logic pll_reference_clock,
  output logic base_clock_output
);
  logic half_ff;
  logic src_tick;
  // crystal only runs while enabled
  assign crystal_clock = osc_en & crystal_tick;
  assign pll_reference_clock = crystal_clock;
  assign src_tick = pll_sel ? vco_tick : crystal_clock;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_ff <= 1'b0;
      base_clock_output <= 1'b0;
    end else begin
      base_clock_output <= 1'b0;
      if (src_tick) begin
        half_ff <= ~half_ff;
        base_clock_output <= half_ff;
      end
    end
  end
endmodule

// ==== core/rbs_regs.sv ====
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - break ending stop/wait sets standby flag
// - write zero or reset clears standby flag
// - reset source read clears after returning
// - power-on sets POR, clears others
// - pin reset sets external flag
// - watchdog reset sets watchdog flag
// - undefined opcode reset sets its flag
// - only opcode fetches set bad-address flag
// - low-supply reset sets its flag
// - break clears allowed only with enable
// - enable zero blocks break clears; readable
// - base clock from crystal or vco halves
// - oscillator runs only when enabled
// - flag cleared in break stays cleared
// - two-step clear protected across break entry
module rbs_regs
  import rbs_pkg::*;
#(
  parameter int NFLAGS = 8
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // reset cause of the reset just released, valid on release
  input wire logic [2:0] reset_cause,
  input wire logic cause_is_fetch,
  // cpu status pins (asynchronous)
  input wire logic break_state,
  input wire logic standby_exit,
  input wire logic exit_by_break,
  // peripheral flag events
  input wire logic [NFLAGS-1:0] periph_set,
  input wire logic [NFLAGS-1:0] periph_step1,
  input wire logic [NFLAGS-1:0] periph_step2,
  output logic [NFLAGS-1:0] periph_flags,
  output logic clear_allowed,
  // clock generator
  input wire logic crystal_tick,
  input wire logic vco_tick,
  output logic oscillator_enable,
  output logic crystal_clock,
  output logic pll_reference_clock,
  output logic base_clock_output,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [2:0] stat_s;
  logic brk, stby_exit, exit_brk;
  logic standby_flag_ff, nxt_standby_flag;
  logic [7:0] rsrc_ff, nxt_rsrc;
  logic clear_en_ff;
  logic [1:0] clkctl_ff;
  logic rst_d_ff;
  logic [NFLAGS-1:0] pflag_ff, step1_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_hold_ff, w_hold_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  rbs_sync #(.WIDTH(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({break_state, standby_exit, exit_by_break}),
    .q(stat_s)
  );
  assign brk = stat_s[2];
  assign stby_exit = stat_s[1];
  assign exit_brk = stat_s[0];

  // write channel: address and data latched independently
  wire aw_take = s_axi_awvalid & ~aw_hold_ff & ~bvalid_ff;
  wire w_take = s_axi_wvalid & ~w_hold_ff & ~bvalid_ff;
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  wire wr_go = (aw_hold_ff | aw_take) & (w_hold_ff | w_take);
  wire [11:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_lane0 = wr_go & wr_strb[0];
  wire wr_sbs = wr_lane0 & (wr_addr == RBS_BREAK_STANDBY_OFS);
  wire wr_bfc = wr_lane0 & (wr_addr == RBS_BREAK_FLAG_CTRL_OFS);
  wire wr_clk = wr_lane0 & (wr_addr == RBS_CLOCK_CTRL_OFS);
  wire wr_pf = wr_lane0 & (wr_addr == RBS_PERIPH_FLAG_OFS);
  wire wr_hit = (wr_addr == RBS_BREAK_STANDBY_OFS) | (wr_addr == RBS_RESET_SOURCE_OFS) |
                (wr_addr == RBS_BREAK_FLAG_CTRL_OFS) | (wr_addr == RBS_CLOCK_CTRL_OFS) |
                (wr_addr == RBS_CAUSE_OFS) | (wr_addr == RBS_PERIPH_FLAG_OFS);

  // read channel
  assign s_axi_arready = ~rvalid_ff;
  wire rd_go = s_axi_arvalid & ~rvalid_ff;
  wire rd_src = rd_go & (s_axi_araddr == RBS_RESET_SOURCE_OFS);
  wire [NFLAGS-1:0] pflag_rd = pflag_ff;
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      RBS_BREAK_STANDBY_OFS: rd_mux[RBS_STANDBY_EXIT_BIT] = standby_flag_ff;
      RBS_RESET_SOURCE_OFS: rd_mux[7:0] = rsrc_ff;
      RBS_BREAK_FLAG_CTRL_OFS: rd_mux[RBS_CLEAR_EN_BIT] = clear_en_ff;
      RBS_CLOCK_CTRL_OFS: rd_mux[1:0] = clkctl_ff;
      RBS_CAUSE_OFS: rd_mux[3:0] = {brk, reset_cause};
      RBS_PERIPH_FLAG_OFS: rd_mux[NFLAGS-1:0] = pflag_rd;
      default: rd_hit = 1'b0;
    endcase
  end

  // break-exit standby flag: hardware set wins over software clear
  always_comb begin
    nxt_standby_flag = standby_flag_ff;
    if (wr_sbs && !wr_data[RBS_STANDBY_EXIT_BIT]) nxt_standby_flag = 1'b0;
    if (stby_exit && exit_brk) nxt_standby_flag = 1'b1;
  end

  // reset source: cause bit OR'd on each edge from the second edge of the system reset through the first edge after its release
  wire rst_released = rst_d_ff;
  always_comb begin
    nxt_rsrc = rsrc_ff;
    if (rd_src) nxt_rsrc = RBS_ZERO8;
    if (rst_released) begin
      unique case (reset_cause)
        RBS_CAUSE_PIN: nxt_rsrc[RBS_PIN_BIT] = 1'b1;
        RBS_CAUSE_WDOG: nxt_rsrc[RBS_WDOG_BIT] = 1'b1;
        RBS_CAUSE_BADOP: nxt_rsrc[RBS_BADOP_BIT] = 1'b1;
        RBS_CAUSE_BADADR: nxt_rsrc[RBS_BADADR_BIT] = nxt_rsrc[RBS_BADADR_BIT] | cause_is_fetch;
        RBS_CAUSE_LOW_SUPPLY: nxt_rsrc[RBS_LOW_SUPPLY_BIT] = 1'b1;
        default: nxt_rsrc = nxt_rsrc;
      endcase
    end
  end

  // peripheral status flags gated by break protection
  assign clear_allowed = ~brk | clear_en_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pflag_ff[gi] <= 1'b0;
          step1_ff[gi] <= 1'b0;
        end else begin
          // a first step done before break is not honoured while protected
          if (periph_step1[gi] || (wr_pf && wr_data[gi])) begin
            step1_ff[gi] <= 1'b1;
          end
          if (periph_set[gi]) begin
            pflag_ff[gi] <= 1'b1;
          end else if (periph_step2[gi] && step1_ff[gi] && clear_allowed) begin
            pflag_ff[gi] <= 1'b0;
            step1_ff[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign periph_flags = pflag_ff;

  // power-on reset is separate from the system reset so causes survive
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      rsrc_ff <= RBS_RESET_SOURCE_POR;
    end else begin
      rsrc_ff <= nxt_rsrc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_d_ff <= 1'b1;
      standby_flag_ff <= 1'b0;
      clear_en_ff <= 1'b0;
      clkctl_ff <= RBS_CLOCK_CTRL_RST;
    end else begin
      rst_d_ff <= 1'b0;
      standby_flag_ff <= nxt_standby_flag;
      if (wr_bfc) clear_en_ff <= wr_data[RBS_CLEAR_EN_BIT];
      if (wr_clk) clkctl_ff <= wr_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RBS_RESP_OKAY;
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RBS_RESP_OKAY : RBS_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (s_axi_bready) bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RBS_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? RBS_RESP_OKAY : RBS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign oscillator_enable = clkctl_ff[RBS_OSCEN_BIT];

  rbs_clkdiv u_clkdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_en(clkctl_ff[RBS_OSCEN_BIT]),
    .pll_sel(clkctl_ff[RBS_BCS_BIT]),
    .crystal_tick(crystal_tick),
    .vco_tick(vco_tick),
    .crystal_clock(crystal_clock),
    .pll_reference_clock(pll_reference_clock),
    .base_clock_output(base_clock_output)
  );
endmodule

// ==== tb/rbs_regs_asserts.sv ====
`timescale 1ns/1ps
module rbs_regs_asserts #(
  parameter int NFLAGS = 8
) (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // peripheral flags
  input wire logic [NFLAGS-1:0] periph_flags,
  input wire logic [NFLAGS-1:0] periph_step2,
  input wire logic clear_allowed,
  // clock generator
  input wire logic crystal_tick,
  input wire logic oscillator_enable,
  input wire logic crystal_clock,
  input wire logic pll_reference_clock,
  input wire logic base_clock_output,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  osc_gate_a: assert property (crystal_clock == (crystal_tick && oscillator_enable))
    else $error("crystal clock not gated by enable");
  ref_buffer_a: assert property (pll_reference_clock == crystal_clock)
    else $error("reference clock differs from crystal clock");
  base_half_a: assert property (base_clock_output |=> !base_clock_output)
    else $error("base clock faster than half rate");
  // the system reset also clears flags, so the edge after it is left out
  break_guard_a: assert property ($past(aresetn) && |($past(periph_flags) & ~periph_flags) |-> $past(clear_allowed))
    else $error("flag cleared while clearing blocked");
  step_clear_a: assert property ($past(aresetn) |-> (($past(periph_flags) & ~periph_flags) & ~$past(periph_step2)) == '0)
    else $error("flag cleared without second step");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (base_clock_output);
endmodule

bind rbs_regs rbs_regs_asserts #(.NFLAGS(NFLAGS)) u_chk (.aclk, .aresetn, .periph_flags, .periph_step2,
  .clear_allowed, .crystal_tick, .oscillator_enable, .crystal_clock, .pll_reference_clock, .base_clock_output,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ==== tb/reset_break_status_regs_tb.sv ====
`timescale 1ns/1ps
module reset_break_status_regs_tb;
  import rbs_pkg::*;
  logic aclk, aresetn, por_n, cause_is_fetch, break_state, standby_exit, exit_by_break, clear_allowed;
  logic crystal_tick, vco_tick, oscillator_enable, crystal_clock, pll_reference_clock, base_clock_output;
  logic [2:0] reset_cause;
  logic [7:0] periph_set, periph_step1, periph_step2, periph_flags, m;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_total, total_checks, n, p;
  rbs_regs DUT (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (e !== g) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // responses are matched in order; one of each kind is outstanding at most
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
  end
  always @(posedge aclk) begin
    crystal_tick <= $urandom_range(1) != 0;
    vco_tick <= $urandom_range(1) != 0;
  end
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RBS_RESP_OKAY);
    rq.push_back({r, 24'h000000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RBS_RESP_OKAY);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rst(input logic [2:0] c, input logic f, input logic p = 1'b1);
    aresetn <= 1'b0;
    por_n <= p;
    reset_cause <= c;
    cause_is_fetch <= f;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  // status pins pass a two-stage synchroniser, so each change is given four edges
  task automatic sbx(input logic b);
    standby_exit <= 1'b1;
    exit_by_break <= b;
    repeat (4) @(posedge aclk);
    standby_exit <= 1'b0;
    exit_by_break <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic brk(input logic b);
    break_state <= b;
    repeat (4) @(posedge aclk);
  endtask
  task automatic pf(input logic [2:0] k);
    periph_set <= k[2] ? m : 8'h00;
    periph_step1 <= k[1] ? m : 8'h00;
    periph_step2 <= k[0] ? m : 8'h00;
    @(posedge aclk);
    periph_set <= 8'h00;
    periph_step1 <= 8'h00;
    periph_step2 <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    #100us;
    err_total++;
    results();
  end
  initial begin
    void'($urandom(39426));
    {aresetn, por_n, cause_is_fetch, break_state, standby_exit, exit_by_break, crystal_tick, vco_tick} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, reset_cause} = '0;
    {periph_set, periph_step1, periph_step2, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    m = 8'h01 << $urandom_range(7);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    rd(RBS_RESET_SOURCE_OFS, RBS_RESET_SOURCE_POR);
    rd(RBS_RESET_SOURCE_OFS, RBS_ZERO8);
    rd(RBS_BREAK_FLAG_CTRL_OFS, RBS_ZERO8);
    rd(RBS_CLOCK_CTRL_OFS, 8'h02);
    rd(12'h020, RBS_ZERO8, RBS_RESP_SLVERR);
    wr(12'h020, 8'h5A, RBS_RESP_SLVERR);
    rst(RBS_CAUSE_PIN, 1'b0);
    rst(RBS_CAUSE_WDOG, 1'b0);
    rd(RBS_RESET_SOURCE_OFS, 8'h60);
    rst(RBS_CAUSE_BADADR, 1'b0);
    rd(RBS_RESET_SOURCE_OFS, RBS_ZERO8);
    for (n = 3; n <= 5; n++) begin
      rst(3'(n), 1'b1);
      rd(RBS_RESET_SOURCE_OFS, (n == 3) ? 8'h10 : (n == 4) ? 8'h08 : 8'h02);
    end
    rst(RBS_CAUSE_PIN, 1'b0);
    rst(RBS_CAUSE_NONE, 1'b0, 1'b0);
    rd(RBS_RESET_SOURCE_OFS, RBS_RESET_SOURCE_POR);
    sbx(1'b0);
    rd(RBS_BREAK_STANDBY_OFS, RBS_ZERO8);
    sbx(1'b1);
    rd(RBS_BREAK_STANDBY_OFS, 8'h02);
    rst(RBS_CAUSE_NONE, 1'b0);
    rd(RBS_BREAK_STANDBY_OFS, RBS_ZERO8);
    sbx(1'b1);
    wr(RBS_BREAK_STANDBY_OFS, 8'h00);
    rd(RBS_BREAK_STANDBY_OFS, RBS_ZERO8);
    // first step lands before break; the clear must wait until break ends
    pf(3'b100);
    pf(3'b010);
    brk(1'b1);
    chk("clear_allowed", 34'h0, {33'h0, clear_allowed});
    pf(3'b001);
    chk("flag", 34'h1, {33'h0, |(periph_flags & m)});
    brk(1'b0);
    pf(3'b001);
    chk("flag", 34'h0, {33'h0, |(periph_flags & m)});
    wr(RBS_BREAK_FLAG_CTRL_OFS, 8'h80);
    rd(RBS_BREAK_FLAG_CTRL_OFS, 8'h80);
    pf(3'b100);
    brk(1'b1);
    pf(3'b010);
    pf(3'b001);
    chk("flag", 34'h0, {33'h0, |(periph_flags & m)});
    brk(1'b0);
    chk("flag", 34'h0, {33'h0, |(periph_flags & m)});
    wr(RBS_CLOCK_CTRL_OFS, 8'h00);
    chk("osc_en", 34'h0, {33'h0, oscillator_enable});
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      n += int'(crystal_clock | pll_reference_clock);
    end
    chk("osc_off", 34'h0, 34'(n));
    wr(RBS_CLOCK_CTRL_OFS, 8'h03);
    rd(RBS_CLOCK_CTRL_OFS, 8'h03);
    // base pulses lag the source ticks by one edge, hence the small margin
    n = 0;
    p = 0;
    repeat (40) begin
      @(posedge aclk);
      n += int'(vco_tick);
      p += int'(base_clock_output);
    end
    chk("base_rate", 34'h1, 34'(2 * p >= n - 2 && 2 * p <= n + 2));
    results();
  end
endmodule
